// >>> design/mac_frame_filter_map.svh
`ifndef MAC_FRAME_FILTER_MAP_SVH
`define MAC_FRAME_FILTER_MAP_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_TXLEN 8'h04
`define REG_PANSHORT 8'h08
`define REG_EUI_LO 8'h0c
`define REG_EUI_HI 8'h10
`define REG_STATUS 8'h14

// Address windows, selected by address bits 11:10
`define WIN_REGS 2'b00
`define WIN_TXBUF 2'b01
`define WIN_RXBUF 2'b10

// Control register fields
`define CTRL_TXSTART 0
`define CTRL_FILTER_EN 1
`define CTRL_AUTOACK_EN 2
`define CTRL_ACKPEND 3

// Status register fields
`define STAT_TXBUSY 0
`define STAT_FRAME_READY 1
`define STAT_FCS_ERR 2
`define STAT_FILT_REJ 3
`define STAT_ACK_SENT 4
`define STAT_RXLEN_LSB 16

// Reset values
`define PAN_RESET 16'hffff
`define SHORT_RESET 16'hffff
`define EUI_RESET 64'h0000_0000_0000_0000
`define TXLEN_RESET 10'h00c

// Frame constants
`define FCS_POLY_REFLECTED 16'h8408
`define FCS_OCTETS 10'h002
`define ACK_FRAME_LEN 10'h005
`define BROADCAST_ID 16'hffff
`define HDR_FIXED_OCTETS 10'h003

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// >>> design/mac_frame_filter_pkg.sv
package mac_frame_filter_pkg;

  typedef enum logic [2:0] {
    FT_BEACON = 3'h0,
    FT_DATA = 3'h1,
    FT_ACK = 3'h2,
    FT_COMMAND = 3'h3
  } frameType_type;

  typedef enum logic [1:0] {
    AM_NONE = 2'h0,
    AM_RESERVED = 2'h1,
    AM_SHORT = 2'h2,
    AM_EXTENDED = 2'h3
  } addrMode_type;

  // Frame control field, bit 15 first
  typedef struct packed {
    logic [1:0] srcMode;
    logic [1:0] version;
    logic [1:0] dstMode;
    logic [2:0] reserved;
    logic panComp;
    logic ackReq;
    logic pending;
    logic security;
    logic [2:0] frameType;
  } frameControl_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_FCS_LO = 2'b11,
    TX_FCS_HI = 2'b10
  } txState_type;

  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic filterEn;
    logic autoAckEn;
    logic ackPendCfg;
    logic [9:0] txLenCfg;
    logic [15:0] panId;
    logic [15:0] shortAddr;
    logic [63:0] eui;
    logic txReq;
    logic frameReady;
    logic fcsErr;
    logic filtRej;
    logic ackSent;
    logic [9:0] rxLen;
    txState_type txState;
    logic [9:0] txIdx;
    logic [9:0] txLen;
    logic txAck;
    logic txValid;
    logic [7:0] txOut;
    logic ackPending;
    logic [7:0] ackSeq;
    logic [9:0] rxIdx;
    frameControl_type rxFc;
    logic [7:0] rxSeq;
    logic [15:0] dstPan;
    logic [63:0] dstAddr;
  } state_type;

endpackage : mac_frame_filter_pkg

// >>> design/fcs_crc16.sv
`timescale 1ns/1ps
`include "mac_frame_filter_map.svh"

module fcs_crc16
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic enable,
  input wire logic [7:0] data,
  output logic [15:0] crc,
  output logic [15:0] crcNext
);

  // Octets enter least significant bit first, as they go on air
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    logic fb;
    v = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = v[0] ^ d[i];
      v = {1'b0, v[15:1]};
      if (fb)
      begin
        v = v ^ `FCS_POLY_REFLECTED;
      end
    end
    return v;
  endfunction : step

  assign crcNext = step(clear ? 16'h0000 : crc, data);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc <= 16'h0000;
    end
    else if (enable)
    begin
      crc <= crcNext;
    end
    else if (clear)
    begin
      crc <= 16'h0000;
    end
  end

endmodule : fcs_crc16

// >>> design/mac_frame_filter_autoack.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mac_frame_filter_map.svh"
// Notes on behaviour
// - Every frame opens with a 16-bit frame control field parsed first.
// - Frame type in bits 2:0; beacon, data, ack, command; 100-111 reserved.
// - Secured frames get no security processing; bytes pass through unchanged.
// - Incoming frame-pending bit is ignored; the host deals with it.
// - Auto-ack frame-pending bit follows the host acknowledgement-pending setting.
// - No acknowledgement is sent when the ack-request bit is clear.
// - Auto-ack only for filtered data or command frames requesting ack.
// - Compression with both addresses: only destination PAN present, shared.
// - Without compression each PAN field exists exactly with its address.
// - Destination mode alone locates destination PAN and address.
// - Destination mode bits 11:10: none, reserved, short, extended.
// - Source mode bits 15:14: none, reserved, short, extended.
// - Frame version 0 or 1 accepted; other versions rejected.
// - Auto-ack copies the received sequence number.
// - Transmit buffer sent for programmed length, last two octets FCS.
// - Every received frame has its FCS checked.
// - Filtering accepts broadcast, PAN plus matching extended id, or PAN plus short.
// - Accepted frames land in receive buffer with length reported.

module mac_frame_filter_autoack #(
  parameter int BUF_DEPTH = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast
);

  localparam int BUF_AW = $clog2(BUF_DEPTH);

  function automatic mac_frame_filter_pkg::state_type resetState();
    mac_frame_filter_pkg::state_type s;
    s = '0;
    s.panId = `PAN_RESET;
    s.shortAddr = `SHORT_RESET;
    s.eui = `EUI_RESET;
    s.txLenCfg = `TXLEN_RESET;
    return s;
  endfunction : resetState

  localparam mac_frame_filter_pkg::state_type STATE_RESET = resetState();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction : merge

  mac_frame_filter_pkg::state_type r;
  mac_frame_filter_pkg::state_type next_r;
  logic [7:0] txMem [BUF_DEPTH];
  logic [7:0] rxMem [BUF_DEPTH];
  logic [15:0] crcTx;
  logic [15:0] crcRxNext;
  logic wrFire;
  logic arFire;
  logic txFire;
  logic txCrcClear;
  logic txCrcEnable;
  logic rxEnd;
  logic fcsOk;
  logic versionOk;
  logic filterOk;
  logic accept;
  logic ackWanted;
  logic lastDataBeat;
  logic [9:0] hdrNeed;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic [7:0] ackByte;
  logic [7:0] nextTxByte;
  logic [9:0] len2;
  mac_frame_filter_pkg::frameControl_type fc;

  assign fc = r.rxFc;
  assign wrFire = awvalid && wvalid && !r.bvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign arFire = arvalid && !r.rvalid;
  assign arready = !r.rvalid;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign txValid = r.txValid;
  assign txData = r.txOut;
  assign txLast = r.txValid && (r.txState == mac_frame_filter_pkg::TX_FCS_HI);
  assign txFire = r.txValid && txReady;
  assign rxEnd = rxValid && rxLast;

  assign ctrlWord = {28'h0000000, r.ackPendCfg, r.autoAckEn, r.filterEn, r.txReq};
  assign statusWord = {6'h00, r.rxLen, 11'h000, r.ackSent, r.filtRej, r.fcsErr,
                       r.frameReady, r.txState != mac_frame_filter_pkg::TX_IDLE};

  // Acknowledgement octet that follows the one now on offer
  always_comb
  begin
    unique case (r.txIdx[1:0])
      2'h0: ackByte = 8'h00;
      2'h1: ackByte = r.ackSeq;
      default: ackByte = 8'h00;
    endcase
  end

  // Host bytes go out verbatim, secured or not
  assign nextTxByte = txMem[BUF_AW'(10'(r.txIdx + 10'h001))];
  assign lastDataBeat = txFire && (r.txState == mac_frame_filter_pkg::TX_DATA)
                        && (10'(r.txIdx + 10'h001) == 10'(r.txLen - `FCS_OCTETS));
  assign len2 = (r.txLenCfg < `FCS_OCTETS) ? `FCS_OCTETS : r.txLenCfg;
  assign txCrcClear = (r.txState == mac_frame_filter_pkg::TX_IDLE) && (r.ackPending || r.txReq);
  assign txCrcEnable = txFire && (r.txState == mac_frame_filter_pkg::TX_DATA);

  fcs_crc16 txCrc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(txCrcClear),
    .enable(txCrcEnable),
    .data(r.txOut),
    .crc(crcTx),
    .crcNext()
  );

  fcs_crc16 rxCrc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(rxValid && (r.rxIdx == 10'h000)),
    .enable(rxValid),
    .data(rxData),
    .crc(),
    .crcNext(crcRxNext)
  );

  // Receive verdict; the frame-pending and security bits are never consulted
  assign hdrNeed = fc.dstMode[1] ? ((fc.dstMode == mac_frame_filter_pkg::AM_EXTENDED) ?
                   10'h00d : 10'h007) : `HDR_FIXED_OCTETS;
  assign fcsOk = (crcRxNext == 16'h0000);
  assign versionOk = (fc.version <= 2'h1);
  always_comb
  begin
    logic panHit;
    logic addrHit;
    logic modesOk;
    logic compOk;
    addrHit = 1'b0;
    modesOk = 1'b0;
    compOk = 1'b0;
    panHit = (r.dstPan == r.panId) || (r.dstPan == `BROADCAST_ID);
    unique case (fc.dstMode)
      mac_frame_filter_pkg::AM_SHORT:
        addrHit = panHit && ((r.dstAddr[63:48] == r.shortAddr)
                  || (r.dstAddr[63:48] == `BROADCAST_ID));
      mac_frame_filter_pkg::AM_EXTENDED:
        addrHit = panHit && (r.dstAddr == r.eui);
      mac_frame_filter_pkg::AM_NONE:
        addrHit = (fc.frameType == mac_frame_filter_pkg::FT_BEACON);
      default:
        addrHit = 1'b0;
    endcase
    modesOk = (fc.srcMode != mac_frame_filter_pkg::AM_RESERVED);
    compOk = !fc.panComp || (fc.dstMode[1] && fc.srcMode[1]);
    filterOk = !r.filterEn || (!fc.frameType[2] && modesOk && compOk && addrHit
               && (r.rxIdx >= 10'(hdrNeed + 10'h001)));
  end
  assign accept = fcsOk && versionOk && filterOk;
  assign ackWanted = accept && r.filterEn && r.autoAckEn && fc.ackReq
                     && ((fc.frameType == mac_frame_filter_pkg::FT_DATA)
                     || (fc.frameType == mac_frame_filter_pkg::FT_COMMAND));

  always_comb
  begin
    logic [31:0] m;
    logic ackDone;
    m = 32'h00000000;
    ackDone = 1'b0;
    next_r = r;
    unique case (r.txState)
      mac_frame_filter_pkg::TX_IDLE:
      begin
        next_r.txIdx = 10'h000;
        // A pending acknowledgement goes ahead of a host frame
        if (r.ackPending)
        begin
          next_r.ackPending = 1'b0;
          next_r.txAck = 1'b1;
          next_r.txLen = `ACK_FRAME_LEN;
          next_r.txState = mac_frame_filter_pkg::TX_DATA;
          next_r.txOut = {3'h0, r.ackPendCfg, 1'b0, mac_frame_filter_pkg::FT_ACK};
          next_r.txValid = 1'b1;
        end
        else if (r.txReq)
        begin
          next_r.txReq = 1'b0;
          next_r.txAck = 1'b0;
          next_r.txLen = len2;
          next_r.txOut = txMem[0];
          next_r.txValid = (len2 != `FCS_OCTETS);
          next_r.txState = (len2 == `FCS_OCTETS) ? mac_frame_filter_pkg::TX_FCS_LO :
                           mac_frame_filter_pkg::TX_DATA;
        end
      end
      mac_frame_filter_pkg::TX_DATA:
      begin
        if (txFire)
        begin
          next_r.txIdx = 10'(r.txIdx + 10'h001);
          if (lastDataBeat)
          begin
            next_r.txState = mac_frame_filter_pkg::TX_FCS_LO;
            next_r.txValid = 1'b0;
          end
          else
          begin
            next_r.txOut = r.txAck ? ackByte : nextTxByte;
          end
        end
      end
      mac_frame_filter_pkg::TX_FCS_LO:
      begin
        // One idle cycle lets the checksum absorb the final payload octet
        if (!r.txValid)
        begin
          next_r.txValid = 1'b1;
          next_r.txOut = crcTx[7:0];
        end
        else if (txFire)
        begin
          next_r.txState = mac_frame_filter_pkg::TX_FCS_HI;
          next_r.txOut = crcTx[15:8];
        end
      end
      mac_frame_filter_pkg::TX_FCS_HI:
      begin
        if (txFire)
        begin
          next_r.txState = mac_frame_filter_pkg::TX_IDLE;
          next_r.txValid = 1'b0;
          ackDone = r.txAck;
        end
      end
    endcase

    if (r.bvalid && bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (wrFire)
    begin
      next_r.bvalid = 1'b1;
      next_r.bresp = `RESP_OKAY;
      if (awaddr[11:10] == `WIN_REGS)
      begin
        unique case (awaddr[7:0])
          `REG_CTRL:
          begin
            m = merge(ctrlWord, wdata, wstrb);
            next_r.filterEn = m[`CTRL_FILTER_EN];
            next_r.autoAckEn = m[`CTRL_AUTOACK_EN];
            next_r.ackPendCfg = m[`CTRL_ACKPEND];
            if (wstrb[0] && wdata[`CTRL_TXSTART])
            begin
              next_r.txReq = 1'b1;
            end
          end
          `REG_TXLEN:
          begin
            m = merge({22'h000000, r.txLenCfg}, wdata, wstrb);
            next_r.txLenCfg = m[9:0];
          end
          `REG_PANSHORT:
          begin
            m = merge({r.panId, r.shortAddr}, wdata, wstrb);
            {next_r.panId, next_r.shortAddr} = m;
          end
          `REG_EUI_LO:
            next_r.eui[31:0] = merge(r.eui[31:0], wdata, wstrb);
          `REG_EUI_HI:
            next_r.eui[63:32] = merge(r.eui[63:32], wdata, wstrb);
          `REG_STATUS:
          begin
            if (wstrb[0])
            begin
              next_r.frameReady = r.frameReady & ~wdata[`STAT_FRAME_READY];
              next_r.fcsErr = r.fcsErr & ~wdata[`STAT_FCS_ERR];
              next_r.filtRej = r.filtRej & ~wdata[`STAT_FILT_REJ];
              next_r.ackSent = r.ackSent & ~wdata[`STAT_ACK_SENT];
            end
          end
          default:
            next_r.bresp = `RESP_DECERR;
        endcase
      end
      else if (awaddr[11:10] != `WIN_TXBUF)
      begin
        next_r.bresp = `RESP_DECERR;
      end
    end

    if (r.rvalid && rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (arFire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `RESP_OKAY;
      next_r.rdata = 32'h00000000;
      if (araddr[11:10] == `WIN_RXBUF)
      begin
        next_r.rdata = {24'h000000, rxMem[araddr[BUF_AW+1:2]]};
      end
      else if (araddr[11:10] == `WIN_REGS)
      begin
        unique case (araddr[7:0])
          `REG_CTRL: next_r.rdata = ctrlWord;
          `REG_TXLEN: next_r.rdata = {22'h000000, r.txLenCfg};
          `REG_PANSHORT: next_r.rdata = {r.panId, r.shortAddr};
          `REG_EUI_LO: next_r.rdata = r.eui[31:0];
          `REG_EUI_HI: next_r.rdata = r.eui[63:32];
          `REG_STATUS: next_r.rdata = statusWord;
          default: next_r.rresp = `RESP_DECERR;
        endcase
      end
      else if (araddr[11:10] != `WIN_TXBUF)
      begin
        next_r.rresp = `RESP_DECERR;
      end
    end

    // Hardware sets come after software clears so a coincident event survives
    if (ackDone)
    begin
      next_r.ackSent = 1'b1;
    end
    if (rxValid)
    begin
      next_r.rxIdx = rxLast ? 10'h000 : 10'(r.rxIdx + 10'h001);
      if (r.rxIdx == 10'h000)
      begin
        next_r.rxFc[7:0] = rxData;
      end
      else if (r.rxIdx == 10'h001)
      begin
        next_r.rxFc[15:8] = rxData;
      end
      else if (r.rxIdx == 10'h002)
      begin
        next_r.rxSeq = rxData;
      end
      // Destination PAN always precedes its address; compression only drops the source PAN
      else if (fc.dstMode[1] && (r.rxIdx < 10'h005))
      begin
        next_r.dstPan = {rxData, r.dstPan[15:8]};
      end
      else if (fc.dstMode[1] && (r.rxIdx < hdrNeed))
      begin
        next_r.dstAddr = {rxData, r.dstAddr[63:8]};
      end
    end
    if (rxEnd)
    begin
      if (accept)
      begin
        next_r.frameReady = 1'b1;
        next_r.rxLen = 10'(r.rxIdx + 10'h001);
      end
      else if (!fcsOk)
      begin
        next_r.fcsErr = 1'b1;
      end
      else
      begin
        next_r.filtRej = 1'b1;
      end
      if (ackWanted)
      begin
        next_r.ackPending = 1'b1;
        next_r.ackSeq = r.rxSeq;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= STATE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Buffers; every received octet is stored, the host sees only accepted lengths
  always_ff @(posedge clk)
  begin
    if (wrFire && (awaddr[11:10] == `WIN_TXBUF) && wstrb[0])
    begin
      txMem[awaddr[BUF_AW+1:2]] <= wdata[7:0];
    end
    if (rxValid)
    begin
      rxMem[r.rxIdx[BUF_AW-1:0]] <= rxData;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence fcsLoOffer;
    (r.txState == mac_frame_filter_pkg::TX_FCS_LO) && r.txValid && (txData == crcTx[7:0]);
  endsequence
  sequence ackSeqOffer;
    r.txAck && r.txValid && (r.txState == mac_frame_filter_pkg::TX_DATA) && (r.txIdx == 10'h002);
  endsequence

  fcs_tail_a: assert property (lastDataBeat |=> !txValid ##1 fcsLoOffer)
    else $error("FCS low octet not offered after payload");
  fcs_last_a: assert property (txLast && txReady |=> !txValid)
    else $error("Frame continues after FCS high octet");
  ack_seq_a: assert property (ackSeqOffer |-> txData == r.ackSeq)
    else $error("Ack sequence number not echoed");
  ack_pend_a: assert property (r.txAck && txValid && (r.txIdx == 10'h000)
      && (r.txState == mac_frame_filter_pkg::TX_DATA) |-> txData[4] == r.ackPendCfg)
    else $error("Ack pending bit does not follow setting");
  no_ack_req_a: assert property (rxEnd && !fc.ackReq && !r.ackPending |=> !r.ackPending)
    else $error("Ack queued without request");
  ack_type_a: assert property (rxEnd && !r.ackPending && !(fc.ackReq
      && ((fc.frameType == mac_frame_filter_pkg::FT_DATA)
      || (fc.frameType == mac_frame_filter_pkg::FT_COMMAND))) |=> !r.ackPending)
    else $error("Ack queued for wrong frame type");
  fcs_check_a: assert property (rxEnd && (crcRxNext != 16'h0000)
      |=> r.fcsErr && $stable(r.rxLen))
    else $error("Bad FCS frame not flagged");
  version_rej_a: assert property (rxEnd && fc.version[1] |=> r.fcsErr || r.filtRej)
    else $error("Bad frame version accepted");
  dst_reserved_a: assert property (rxEnd && r.filterEn
      && (fc.dstMode == mac_frame_filter_pkg::AM_RESERVED) |=> $stable(r.rxLen))
    else $error("Reserved destination mode accepted");
  accept_len_a: assert property (rxEnd && accept
      |=> r.frameReady && (r.rxLen == $past(r.rxIdx) + 10'h001))
    else $error("Accepted frame length not reported");

endmodule : mac_frame_filter_autoack

// >>> verification/air_node_model.sv
`timescale 1ns/1ps

module air_node_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLast
);
  typedef logic [7:0] oct_type[$];
  logic [8:0] got[$];

  initial
  begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
  end

  // Stalling every other cycle forces the sender to hold each octet
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      txReady <= 1'b0;
    else
      txReady <= slow ? !txReady : 1'b1;

  always @(posedge clk)
    if (rst_n && txValid && txReady)
      got.push_back({txLast, txData});

  function automatic logic [15:0] crcOf(input oct_type f);
    logic [15:0] c;
    c = 16'h0000;
    foreach (f[i])
      for (int b = 0; b < 8; b++)
        c = (c[0] ^ f[i][b]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction : crcOf

  // Callers set ack request only in data or command frames
  task automatic sendFrame(input oct_type f, input logic bad);
    logic [15:0] c;
    c = crcOf(f);
    f.push_back(c[7:0] ^ {7'h00, bad});
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      rxValid <= 1'b1;
      rxData <= f[i];
      rxLast <= (i == f.size() - 1);
      @(posedge clk);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    // Idle line shows no stale octet
    rxData <= ~f[f.size() - 1];
  endtask : sendFrame
endmodule : air_node_model

// >>> verification/mac_frame_filter_autoack_tb.sv
`timescale 1ns/1ps
`include "mac_frame_filter_map.svh"

module mac_frame_filter_autoack_tb;
  typedef logic [7:0] oct_type[$];
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] prot = 3'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic slow = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, txValid, txLast, txReady, rxValid, rxLast;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] txData, rxData;
  logic pend = 1'b1;
  logic [9:0] lastLen = 10'h000;
  logic [7:0] seq = 8'hfd;
  int num_errors = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  mac_frame_filter_autoack mac_frame_filter_autoack_inst (.clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady), .rxValid(rxValid),
    .rxData(rxData), .rxLast(rxLast));

  air_node_model air_node_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow),
    .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic bound(input int n);
    if (n >= 400)
    begin
      num_errors++;
      finish_test();
    end
  endtask : bound

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do @(posedge clk); while (!(awready && wready) && ++n < 400);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid && ++n < 400);
    bound(n);
    bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, bresp});
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do @(posedge clk); while (!arready && ++n < 400);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid && ++n < 400);
    bound(n);
    rready <= 1'b0;
    // Read data of a refused access carries no meaning
    if (r == `RESP_OKAY)
      chk("rdata", d, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
    @(posedge clk);
  endtask : rd

  task automatic chkTx(input oct_type e);
    logic [15:0] c;
    int n;
    c = air_node_model_inst.crcOf(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (n = 0; n < 400 && air_node_model_inst.got.size() < e.size(); n++)
      @(posedge clk);
    bound(n);
    foreach (e[i])
      chk("tx octet", {23'h0, i == e.size() - 1, e[i]}, {23'h0, air_node_model_inst.got[i]});
    air_node_model_inst.got.delete();
  endtask : chkTx

  function automatic oct_type mk(input logic [15:0] fc, input logic [15:0] dst);
    seq = seq + 8'h01;
    return '{fc[7:0], fc[15:8], seq, 8'h34, 8'h12, dst[7:0], dst[15:8], 8'hcd, 8'hab, 8'h77};
  endfunction : mk

  task automatic rxCase(input oct_type f, input logic bad, input logic [4:0] fl);
    air_node_model_inst.sendFrame(f, bad);
    if (fl[4])
      chkTx('{{3'h0, pend, 4'h2}, 8'h00, f[2]});
    else
    begin
      repeat (30) @(posedge clk);
      chk("ack count", 32'h0, air_node_model_inst.got.size());
    end
    if (fl[1])
    begin
      lastLen = 10'(f.size() + 2);
      rd(12'h808, {24'h0, f[2]}, `RESP_OKAY);
    end
    rd(`REG_STATUS, {6'h0, lastLen, 11'h0, fl}, `RESP_OKAY);
    wr(`REG_STATUS, 32'h1e, `RESP_OKAY);
  endtask : rxCase

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`REG_PANSHORT, 32'hffffffff, `RESP_OKAY);
    rd(`REG_TXLEN, 32'h0000000c, `RESP_OKAY);
    rd(`REG_EUI_HI, 32'h0, `RESP_OKAY);
    rd(12'h01c, 32'h0, `RESP_DECERR);
    wr(12'h018, 32'h0, `RESP_DECERR);
    wr(12'h400, 32'h41, `RESP_OKAY);
    wr(12'h404, 32'h42, `RESP_OKAY);
    wr(12'h408, 32'h43, `RESP_OKAY);
    wr(`REG_TXLEN, 32'h5, `RESP_OKAY);
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    chkTx('{8'h41, 8'h42, 8'h43});
    slow <= 1'b0;
    wr(`REG_PANSHORT, 32'h1234abcd, `RESP_OKAY);
    wr(`REG_EUI_LO, 32'h89abcdef, `RESP_OKAY);
    wr(`REG_EUI_HI, 32'h01234567, `RESP_OKAY);
    wr(`REG_CTRL, 32'he, `RESP_OKAY);
    rxCase(mk(16'h9861, 16'habcd), 1'b0, 5'h12);
    rxCase(mk(16'h9841, 16'hffff), 1'b0, 5'h02);
    rxCase(mk(16'h9861, 16'habcd), 1'b1, 5'h04);
    rxCase(mk(16'ha861, 16'habcd), 1'b0, 5'h08);
    rxCase(mk(16'h9861, 16'h0001), 1'b0, 5'h08);
    rxCase(mk(16'h9844, 16'habcd), 1'b0, 5'h08);
    rxCase(mk(16'h5801, 16'habcd), 1'b0, 5'h08);
    rxCase(mk(16'h9859, 16'habcd), 1'b0, 5'h02);
    rxCase('{8'h21, 8'h9c, 8'h60, 8'h34, 8'h12, 8'hef, 8'hcd, 8'hab, 8'h89, 8'h67, 8'h45,
      8'h23, 8'h01, 8'h34, 8'h12, 8'hcd, 8'hab}, 1'b0, 5'h12);
    rxCase('{8'h00, 8'h80, 8'h07, 8'h34, 8'h12, 8'hcd, 8'hab, 8'h77}, 1'b0, 5'h02);
    rxCase(mk(16'h9401, 16'habcd), 1'b0, 5'h08);
    pend = 1'b0;
    wr(`REG_CTRL, 32'h6, `RESP_OKAY);
    rxCase(mk(16'h9863, 16'habcd), 1'b0, 5'h12);
    finish_test();
  end
endmodule : mac_frame_filter_autoack_tb
